/* File: rtl/spm_pkg.sv */
package spm_pkg;

	// ----------------------------------------
	// slave-side register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_MBX0     = 8'h20;
	localparam logic [7:0] ADDR_MBX1     = 8'h21;
	localparam logic [7:0] ADDR_MBX2     = 8'h22;
	localparam logic [7:0] ADDR_STATUS   = 8'h23;
	localparam logic [7:0] ADDR_CTRL     = 8'h24;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h25;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h26;
	localparam logic [7:0] ADDR_PP_DATA  = 8'h27;

	// ----------------------------------------
	// master-side register select codes
	// ----------------------------------------
	localparam logic [1:0] EXT_MBX0   = 2'h0;
	localparam logic [1:0] EXT_STATUS = 2'h3;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_IGNORE_BOOT = 7;
	localparam int CTRL_BOOT_HI     = 6;
	localparam int CTRL_BOOT_LO     = 5;
	localparam int CTRL_MODE_LSB    = 2;
	localparam int CTRL_PRIO_LSB    = 0;
	localparam int STAT_IN_LSB      = 0;
	localparam int STAT_OUT_LSB     = 4;
	localparam int IRQ_INBOUND      = 0;
	localparam int IRQ_MST_WRITE    = 1;
	localparam int IRQ_MST_READ     = 2;

	// ----------------------------------------
	// codes and reset values
	// ----------------------------------------
	localparam logic [1:0] MODE_PP_IN    = 2'h0;
	localparam logic [1:0] MODE_PP_OUT   = 2'h1;
	localparam logic [1:0] MODE_SLAVE    = 2'h2;
	localparam logic [1:0] MODE_AUX      = 2'h3;
	localparam logic [1:0] PRIO_OFF      = 2'h0;
	localparam logic [1:0] BOOT_COLD     = 2'h1;
	localparam logic [1:0] BOOT_SAMPLE   = 2'h2;
	localparam logic [1:0] BOOT_DONE     = 2'h3;
	localparam logic [2:0] IRQ_MASK_RST  = 3'h0;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] data;
		logic [1:0] sel;
		logic       selN;
		logic       rdN;
		logic       wrN;
		logic [1:0] boot;
	} spm_pins_t;

	typedef struct packed {
		spm_pins_t       sync1;
		spm_pins_t       sync2;
		logic            mWrActive;
		logic [7:0]      mWrData;
		logic [1:0]      mWrSel;
		logic            mRdActive;
		logic [1:0]      mRdSel;
		logic [2:0][7:0] inReg;
		logic [2:0][7:0] outReg;
		logic [2:0]      inFull;
		logic [2:0]      outFull;
		logic            attnN;
		logic            ignoreBoot;
		logic [1:0]      mode;
		logic [1:0]      prio;
		logic [1:0]      bootCnt;
		logic            coldBoot;
		logic [7:0]      ppData;
		logic [2:0]      irqStat;
		logic [2:0]      irqMask;
		logic            irq;
		logic [7:0]      rdData;
		logic [7:0]      pdOut;
		logic            pdOe;
	} spm_state_t;

endpackage

/* File: rtl/spm_mailbox_port.sv */
`timescale 1ns/1ps
`default_nettype none

module spm_mailbox_port
	import spm_pkg::*;
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rstn,
	// slave register port
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdData,
	// master-facing pins
	input  wire logic [7:0] portDataIn,
	output logic      [7:0] portDataOut,
	output logic            portDataOe,
	input  wire logic       regSelectHi,
	input  wire logic       regSelectLo,
	input  wire logic       portSelectN,
	input  wire logic       portReadStrobeN,
	input  wire logic       portWriteStrobeN,
	output logic            attentionOutN,
	// boot mode pins
	input  wire logic       bootModePinHi,
	input  wire logic       bootModePinLo,
	// interrupt and status
	output logic            slaveIrq,
	output logic      [1:0] irqPriority,
	output logic            coldBootActive
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	spm_state_t st_ff;
	spm_state_t nxt_st;
	spm_pins_t  pinsRaw;

	logic       slaveMode;
	logic       mWrLow;
	logic       mRdLow;
	logic       mWrEnd;
	logic       mRdEnd;
	logic [7:0] statusByte;
	logic [7:0] mstRdVal;
	logic       sWr;
	logic       sRd;

	assign pinsRaw = '{data: portDataIn, sel: {regSelectHi, regSelectLo}, selN: portSelectN,
		rdN: portReadStrobeN, wrN: portWriteStrobeN, boot: {bootModePinHi, bootModePinLo}};

	// ----------------------------------------
	// decoded master activity
	// ----------------------------------------
	assign slaveMode  = (st_ff.mode == MODE_SLAVE);
	assign mWrLow     = slaveMode && !st_ff.sync2.selN && !st_ff.sync2.wrN;
	assign mRdLow     = slaveMode && !st_ff.sync2.selN && !st_ff.sync2.rdN;
	assign mWrEnd     = st_ff.mWrActive && !mWrLow;
	assign mRdEnd     = st_ff.mRdActive && !mRdLow;
	assign statusByte = {1'b0, st_ff.outFull, 1'b0, st_ff.inFull};
	assign sWr        = regWr;
	assign sRd        = regRd;

	always_comb begin
		mstRdVal = statusByte;
		if (st_ff.sync2.sel != EXT_STATUS) begin
			mstRdVal = st_ff.outReg[st_ff.sync2.sel];
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = pinsRaw;
		nxt_st.sync2 = st_ff.sync1;

		// master write and read paths
		nxt_st.mWrActive = mWrLow;
		if (mWrLow) begin
			nxt_st.mWrData = st_ff.sync2.data;
			nxt_st.mWrSel  = st_ff.sync2.sel;
		end
		nxt_st.mRdActive = mRdLow;
		if (mRdLow) begin
			nxt_st.mRdSel = st_ff.sync2.sel;
		end

		// pin drive
		nxt_st.pdOe  = mRdLow || (st_ff.mode == MODE_PP_OUT);
		nxt_st.pdOut = mRdLow ? mstRdVal : st_ff.ppData;

		// slave reads: read data and full clears
		nxt_st.rdData = 8'h00;
		if (sRd) begin
			case (regAddr)
				ADDR_MBX0, ADDR_MBX1, ADDR_MBX2: begin
					nxt_st.rdData = st_ff.inReg[regAddr[1:0]];
					nxt_st.inFull[regAddr[1:0]] = 1'b0;
				end
				ADDR_STATUS:   nxt_st.rdData = statusByte;
				ADDR_CTRL:     nxt_st.rdData = {1'b0, st_ff.sync2.boot, 5'h00};
				ADDR_IRQ_STAT: nxt_st.rdData = {5'h00, st_ff.irqStat};
				ADDR_IRQ_MASK: nxt_st.rdData = {5'h00, st_ff.irqMask};
				ADDR_PP_DATA:  nxt_st.rdData = st_ff.sync2.data;
				default:       nxt_st.rdData = 8'h00;
			endcase
		end

		// master read end empties the outbound register
		if (mRdEnd) begin
			if (st_ff.mRdSel != EXT_STATUS) begin
				nxt_st.outFull[st_ff.mRdSel] = 1'b0;
			end
			nxt_st.irqStat[IRQ_MST_READ] = 1'b1;
		end

		// slave writes
		if (sWr) begin
			case (regAddr)
				ADDR_MBX0, ADDR_MBX1, ADDR_MBX2: begin
					nxt_st.outReg[regAddr[1:0]]  = regWrData;
					nxt_st.outFull[regAddr[1:0]] = 1'b1;
				end
				ADDR_STATUS: nxt_st.irqStat[IRQ_INBOUND] = 1'b0;
				ADDR_CTRL: begin
					nxt_st.ignoreBoot = regWrData[CTRL_IGNORE_BOOT];
					nxt_st.mode = regWrData[CTRL_MODE_LSB +: 2];
					nxt_st.prio = regWrData[CTRL_PRIO_LSB +: 2];
					if (regWrData[CTRL_IGNORE_BOOT]) begin
						nxt_st.coldBoot = 1'b0;
					end
				end
				ADDR_IRQ_STAT: nxt_st.irqStat = nxt_st.irqStat & ~regWrData[2:0];
				ADDR_IRQ_MASK: nxt_st.irqMask = regWrData[2:0];
				ADDR_PP_DATA:  nxt_st.ppData = regWrData;
				default: begin
				end
			endcase
		end

		// master write commits when strobe or select rises; sets win over clears
		if (mWrEnd) begin
			if (st_ff.mWrSel == EXT_STATUS) begin
				nxt_st.attnN = 1'b1;
			end else begin
				nxt_st.inReg[st_ff.mWrSel]  = st_ff.mWrData;
				nxt_st.inFull[st_ff.mWrSel] = 1'b1;
				if (st_ff.mWrSel == EXT_MBX0) begin
					nxt_st.irqStat[IRQ_INBOUND] = 1'b1;
				end else begin
					nxt_st.irqStat[IRQ_MST_WRITE] = 1'b1;
				end
			end
		end
		if (mRdEnd) begin
			nxt_st.irqStat[IRQ_MST_READ] = 1'b1;
		end
		if (sWr && regAddr == ADDR_MBX0) begin
			nxt_st.attnN = 1'b0;
		end

		// boot-mode sampling after reset release
		if (st_ff.bootCnt != BOOT_DONE) begin
			nxt_st.bootCnt = st_ff.bootCnt + 2'h1;
		end
		if (st_ff.bootCnt == BOOT_SAMPLE && !st_ff.ignoreBoot &&
			st_ff.sync2.boot == BOOT_COLD) begin
			nxt_st.mode     = MODE_SLAVE;
			nxt_st.coldBoot = 1'b1;
		end

		nxt_st.irq = |(nxt_st.irqStat & nxt_st.irqMask) && (nxt_st.prio != PRIO_OFF);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_ff         <= '0;
			st_ff.attnN   <= 1'b1;
			st_ff.mode    <= MODE_PP_IN;
			st_ff.prio    <= PRIO_OFF;
			st_ff.irqMask <= IRQ_MASK_RST;
			st_ff.sync1   <= '1;
			st_ff.sync2   <= '1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign regRdData      = st_ff.rdData;
	assign portDataOut    = st_ff.pdOut;
	assign portDataOe     = st_ff.pdOe;
	assign attentionOutN  = st_ff.attnN;
	assign slaveIrq       = st_ff.irq;
	assign irqPriority    = st_ff.prio;
	assign coldBootActive = st_ff.coldBoot;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	logic slvMbx0Wr;
	logic mstStatWr;
	logic mstMbx0Wr;
	assign slvMbx0Wr = sWr && regAddr == ADDR_MBX0;
	assign mstStatWr = mWrEnd && st_ff.mWrSel == EXT_STATUS;
	assign mstMbx0Wr = mWrEnd && st_ff.mWrSel == EXT_MBX0;

	drive_gate_a: assert property (portDataOe && st_ff.mode != MODE_PP_OUT |->
		$past(mRdLow) || $past(st_ff.mode) == MODE_PP_OUT) else $error("data pins driven without select and read");
	read_value_a: assert property (mRdLow |=> portDataOut == $past(mstRdVal))
		else $error("wrong value on data pins");
	no_select_a: assert property (st_ff.sync2.selN [*3] |=> !st_ff.mWrActive && !st_ff.mRdActive)
		else $error("strobe taken without select");
	capture_a: assert property (mWrEnd && st_ff.mWrSel != EXT_STATUS |=>
		st_ff.inReg[$past(st_ff.mWrSel)] == $past(st_ff.mWrData))
		else $error("master write not captured");
	attn_low_a: assert property (slvMbx0Wr |=> !attentionOutN ##1 1)
		else $error("attention not asserted");
	attn_high_a: assert property (mstStatWr && !slvMbx0Wr |=> attentionOutN)
		else $error("attention not released");
	full_set_a: assert property (sWr && regAddr == ADDR_MBX1 |=> st_ff.outFull[1])
		else $error("outbound full flag not set");
	full_clr_a: assert property (sRd && regAddr == ADDR_MBX2 && !(mWrEnd && st_ff.mWrSel == 2'h2)
		|=> !st_ff.inFull[2]) else $error("inbound full flag not cleared");
	inbound_a: assert property (mstMbx0Wr |=> st_ff.irqStat[IRQ_INBOUND])
		else $error("inbound interrupt not set");
	inb_clear_a: assert property (sWr && regAddr == ADDR_STATUS && !mstMbx0Wr
		|=> !st_ff.irqStat[IRQ_INBOUND]) else $error("inbound interrupt not cleared");
	prio_off_a: assert property (irqPriority == PRIO_OFF |-> !slaveIrq)
		else $error("interrupt raised while disabled");
	cold_boot_a: assert property (st_ff.bootCnt == BOOT_SAMPLE && !st_ff.ignoreBoot &&
		st_ff.sync2.boot == BOOT_COLD |=> st_ff.mode == MODE_SLAVE && coldBootActive)
		else $error("cold boot did not enable port");
	slave_only_a: assert property (st_ff.mode != MODE_SLAVE |=> !st_ff.mWrActive)
		else $error("master access outside slave mode");

	// ----------------------------------------
	// register port and pin checks
	// ----------------------------------------
	rd_idle_a: assert property (
		!sRd
		|=> regRdData == 8'h00)
		else $error("read data not idle");

	status_rd_a: assert property (
		sRd && regAddr == ADDR_STATUS
		|=> regRdData == $past(statusByte))
		else $error("status read wrong");

	oe_drop_a: assert property (
		!mRdLow && st_ff.mode != MODE_PP_OUT
		|=> !portDataOe)
		else $error("data pins still driven");

	pp_drive_a: assert property (
		st_ff.mode == MODE_PP_OUT
		|=> portDataOe && portDataOut == $past(st_ff.ppData))
		else $error("parallel output not driven");

	no_drive_a: assert property (
		st_ff.mode != MODE_SLAVE && st_ff.mode != MODE_PP_OUT
		|=> !portDataOe)
		else $error("pins driven in input mode");

	attn_hold_a: assert property (
		!slvMbx0Wr && !mstStatWr
		|=> $stable(attentionOutN))
		else $error("attention changed without cause");

	irq_level_a: assert property (
		slaveIrq == (|(st_ff.irqStat & st_ff.irqMask) && st_ff.prio != PRIO_OFF))
		else $error("interrupt level wrong");

	prio_write_a: assert property (
		sWr && regAddr == ADDR_CTRL
		|=> irqPriority == $past(regWrData[CTRL_PRIO_LSB +: 2]))
		else $error("priority not written");

	mode_write_a: assert property (
		sWr && regAddr == ADDR_CTRL && st_ff.bootCnt == BOOT_DONE
		|=> st_ff.mode == $past(regWrData[CTRL_MODE_LSB +: 2]))
		else $error("mode not written");

	boot_quiet_a: assert property (
		st_ff.bootCnt != BOOT_SAMPLE && !(sWr && regAddr == ADDR_CTRL)
		|=> $stable(st_ff.mode))
		else $error("mode changed without cause");

	wr_sync_a: assert property (
		st_ff.mWrActive
		|-> $past(!st_ff.sync2.selN && !st_ff.sync2.wrN))
		else $error("write taken before sync");

	rd_sync_a: assert property (
		st_ff.mRdActive
		|-> $past(!st_ff.sync2.selN && !st_ff.sync2.rdN))
		else $error("read taken before sync");

	// ----------------------------------------
	// per-mailbox flag checks
	// ----------------------------------------
	for (genvar g = 0; g < 3; g++) begin : gen_mbx_chk
		localparam logic [7:0] MBX_ADDR = ADDR_MBX0 + 8'(g);

		out_set_a: assert property (
			sWr && regAddr == MBX_ADDR
			|=> st_ff.outFull[g] && st_ff.outReg[g] == $past(regWrData))
			else $error("outbound mailbox not written");

		in_set_a: assert property (
			mWrEnd && st_ff.mWrSel == 2'(g)
			|=> st_ff.inFull[g] && st_ff.inReg[g] == $past(st_ff.mWrData))
			else $error("inbound mailbox not written");

		in_clr_a: assert property (
			sRd && regAddr == MBX_ADDR && !(mWrEnd && st_ff.mWrSel == 2'(g))
			|=> !st_ff.inFull[g])
			else $error("inbound flag not cleared");

		out_clr_a: assert property (
			mRdEnd && st_ff.mRdSel == 2'(g) && !(sWr && regAddr == MBX_ADDR)
			|=> !st_ff.outFull[g])
			else $error("outbound flag not cleared");

		in_hold_a: assert property (
			!(sRd && regAddr == MBX_ADDR) && !(mWrEnd && st_ff.mWrSel == 2'(g))
			|=> $stable(st_ff.inFull[g]))
			else $error("inbound flag changed without cause");

		out_hold_a: assert property (
			!(sWr && regAddr == MBX_ADDR) && !(mRdEnd && st_ff.mRdSel == 2'(g))
			|=> $stable(st_ff.outFull[g]))
			else $error("outbound flag changed without cause");

		in_data_a: assert property (
			sRd && regAddr == MBX_ADDR
			|=> regRdData == $past(st_ff.inReg[g]))
			else $error("inbound mailbox read wrong");
	end

	master_write_c: cover property (mstMbx0Wr ##[1:20] slaveIrq);
	master_read_c:  cover property (mRdLow ##1 portDataOe ##[1:20] mRdEnd);
	attention_c:    cover property (slvMbx0Wr ##[1:40] mstStatWr);
	cold_boot_c:    cover property (coldBootActive);
	pp_out_c:       cover property (st_ff.mode == MODE_PP_OUT ##1 portDataOe);

endmodule // spm_mailbox_port

`default_nettype wire

/* File: tb/spm_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

module spm_master_model (
	// clock
	input  wire logic       clock,
	// data pins
	input  wire logic [7:0] portDataOut,
	input  wire logic       portDataOe,
	output logic      [7:0] portDataIn,
	// master strobes and selects
	output logic            regSelectHi,
	output logic            regSelectLo,
	output logic            portSelectN,
	output logic            portReadStrobeN,
	output logic            portWriteStrobeN
);
	logic [7:0] drvData;
	logic       drvOn;
	logic [7:0] lastBus;

	// ----------------------------------------
	// wire level, released bus keeps changing
	// ----------------------------------------
	always_comb begin
		if (portDataOe)
			portDataIn = portDataOut;
		else if (drvOn)
			portDataIn = drvData;
		else
			portDataIn = ~lastBus;
	end

	always @(posedge clock) begin
		lastBus <= portDataIn;
	end

	initial begin
		{regSelectHi, regSelectLo, drvOn, lastBus, drvData} = '0;
		{portSelectN, portReadStrobeN, portWriteStrobeN} = 3'h7;
	end

	// ----------------------------------------
	// one access, strobes held six clocks, seven when select is released first
	// ----------------------------------------
	task automatic access(input logic [1:0] sel, input logic wr, input logic csOn,
		input logic csFirst, input logic [7:0] wdata, output logic [7:0] rdata);
		@(posedge clock);
		regSelectHi <= sel[1];
		regSelectLo <= sel[0];
		drvData     <= wdata;
		drvOn       <= wr;
		portSelectN <= !csOn;
		if (wr)
			portWriteStrobeN <= 1'b0;
		else
			portReadStrobeN <= 1'b0;
		repeat (6) @(posedge clock);
		rdata = portDataIn;
		if (csFirst) begin
			portSelectN <= 1'b1;
			@(posedge clock);
		end
		portSelectN      <= 1'b1;
		portWriteStrobeN <= 1'b1;
		portReadStrobeN  <= 1'b1;
		@(posedge clock);
		drvOn <= 1'b0;
		repeat (8) @(posedge clock);
	endtask
endmodule // spm_master_model

`default_nettype wire

/* File: tb/test_spm_mailbox_port.sv */
`timescale 1ns/1ps
`default_nettype none

module test_spm_mailbox_port
	import spm_pkg::*;
;
	logic [7:0] regAddr, regWrData, regRdData, portDataIn, portDataOut, rdVal;
	logic       clock, rstn, regWr, regRd, portDataOe, regSelectHi, regSelectLo;
	logic       portSelectN, portReadStrobeN, portWriteStrobeN, attentionOutN;
	logic       bootModePinHi, bootModePinLo, slaveIrq, coldBootActive;
	logic [1:0] irqPriority;
	int         badCount, totalChecks;

	spm_mailbox_port spm_mailbox_port_inst (.clock, .rstn, .regAddr, .regWrData, .regWr,
		.regRd, .regRdData, .portDataIn, .portDataOut, .portDataOe, .regSelectHi,
		.regSelectLo, .portSelectN, .portReadStrobeN, .portWriteStrobeN, .attentionOutN,
		.bootModePinHi, .bootModePinLo, .slaveIrq, .irqPriority, .coldBootActive);

	spm_master_model spm_master_model_inst (.clock, .portDataOut, .portDataOe, .portDataIn,
		.regSelectHi, .regSelectLo, .portSelectN, .portReadStrobeN, .portWriteStrobeN);

	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		totalChecks++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr   <= a;
		regWrData <= d;
		regWr     <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1 check(regRdData, exp);
	endtask

	task automatic mwr(input logic [1:0] s, input logic [7:0] d, input logic cs, input logic f);
		spm_master_model_inst.access(s, 1'b1, cs, f, d, rdVal);
	endtask

	task automatic mrd(input logic [1:0] s, input logic [7:0] exp);
		spm_master_model_inst.access(s, 1'b0, 1'b1, 1'b0, 8'h00, rdVal);
		check(rdVal, exp);
	endtask

	task automatic doReset(input logic lo);
		bootModePinLo <= lo;
		rstn          <= 1'b0;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		#1;
	endtask

	task automatic tallyAndFinish;
		if (badCount == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial begin
		#200000;
		badCount++;
		tallyAndFinish();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{regAddr, regWrData, regWr, regRd, rstn, bootModePinHi, bootModePinLo} = '0;
		doReset(1'b0);
		check({4'h0, attentionOutN, slaveIrq, portDataOe, coldBootActive}, 8'h08);
		rd(ADDR_CTRL, 8'h00);
		mwr(EXT_MBX0, 8'h5A, 1'b1, 1'b0);
		rd(ADDR_STATUS, 8'h00);
		wr(ADDR_PP_DATA, 8'h5A);
		wr(ADDR_CTRL, 8'h04);
		repeat (2) @(posedge clock);
		#1 check({7'h0, portDataOe}, 8'h01);
		check(portDataOut, 8'h5A);
		rd(ADDR_PP_DATA, 8'h5A);
		wr(ADDR_CTRL, 8'h09);
		wr(ADDR_IRQ_MASK, 8'h01);
		check({6'h0, irqPriority}, 8'h01);
		mwr(EXT_MBX0, 8'hA5, 1'b0, 1'b0);
		rd(ADDR_STATUS, 8'h00);
		mwr(EXT_MBX0, 8'hA5, 1'b1, 1'b1);
		rd(ADDR_STATUS, 8'h01);
		check({7'h0, slaveIrq}, 8'h01);
		rd(ADDR_MBX0, 8'hA5);
		rd(ADDR_STATUS, 8'h00);
		wr(ADDR_STATUS, 8'hFF);
		repeat (2) @(posedge clock);
		#1 check({7'h0, slaveIrq}, 8'h00);
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h00);
		for (int i = 0; i < 3; i++)
			wr(ADDR_MBX0 + 8'(i), 8'h11 * 8'(i + 1));
		repeat (2) @(posedge clock);
		#1 check({7'h0, attentionOutN}, 8'h00);
		mrd(EXT_STATUS, 8'h70);
		for (int i = 0; i < 3; i++)
			mrd(2'(i), 8'h11 * 8'(i + 1));
		check({7'h0, portDataOe}, 8'h00);
		rd(ADDR_STATUS, 8'h00);
		rd(ADDR_IRQ_STAT, 8'h04);
		wr(ADDR_IRQ_STAT, 8'h04);
		rd(ADDR_IRQ_STAT, 8'h00);
		rd(ADDR_IRQ_MASK, 8'h01);
		mwr(EXT_STATUS, 8'h00, 1'b1, 1'b0);
		check({7'h0, attentionOutN}, 8'h01);
		wr(ADDR_CTRL, 8'h08);
		mwr(EXT_MBX0, 8'h3C, 1'b1, 1'b0);
		check({7'h0, slaveIrq}, 8'h00);
		rd(ADDR_MBX0, 8'h3C);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_MBX1, 8'h77);
		mwr(2'h1, 8'h66, 1'b1, 1'b0);
		rd(ADDR_STATUS, 8'h20);
		doReset(1'b1);
		repeat (4) @(posedge clock);
		#1 check({7'h0, coldBootActive}, 8'h01);
		rd(ADDR_CTRL, 8'h20);
		mwr(EXT_MBX0, 8'hC3, 1'b1, 1'b0);
		rd(ADDR_STATUS, 8'h01);
		wr(ADDR_CTRL, 8'h88);
		repeat (2) @(posedge clock);
		#1 check({7'h0, coldBootActive}, 8'h00);
		tallyAndFinish();
	end
endmodule // test_spm_mailbox_port

`default_nettype wire
